// ### watchdog_control_pkg.sv
// constants shared by the watchdog control and status block
package watchdog_control_pkg;
   // =========================================================
   // register byte addresses
   localparam logic [11:0] WDCTL_ADDR  = 12'h0d8;
   localparam logic [11:0] EIE_ADDR    = 12'h0e8;
   localparam logic [11:0] EIP_ADDR    = 12'h0f8;
   localparam logic [11:0] IRQST_ADDR  = 12'h100;
   localparam logic [11:0] IRQMSK_ADDR = 12'h104;
   // =========================================================
   // watchdog control field positions
   localparam int POR_BIT     = 6;
   localparam int CLKSEL_BIT  = 4;
   localparam int TOFLAG_BIT  = 3;
   localparam int CAUSE_BIT   = 2;
   localparam int RSTEN_BIT   = 1;
   localparam int RESTART_BIT = 0;
   // =========================================================
   // interrupt register fields
   localparam int WDT_EN_BIT  = 5;
   localparam int EIE_WIDTH   = 6;
   localparam int EV_TIMEOUT  = 0;
   localparam int EV_WDRESET  = 1;
   localparam int EV_COUNT    = 2;
   localparam logic [EIE_WIDTH-1:0] EIE_RESET = 6'h00;
   localparam logic [EIE_WIDTH-1:0] EIP_RESET = 6'h00;
   // =========================================================
   // timing and bus answers
   localparam int RESET_DELAY_TICKS = 512;
   localparam int DEF_TIMEOUT_TICKS = 65536;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : watchdog_control_pkg

// ### watchdog_control_status.sv
// watchdog control and status block with axi4-lite register access
// Notes on behaviour
// - power-up sets power-on flag; software clears it
// - clock select picks sub-clock or main oscillator
// - a time-out sets the time-out flag unless a warm reset lands in the same cycle
// - time-out flag cleared by software or reset
// - watchdog reset sets cause flag, software clears
// - power-fail reset clears the cause flag
// - reset enable zero leaves cause flag alone
// - reset enable one arms time-out system reset
// - restart returns counter to initial state
// - restart bit clears itself after acting
// - system reset 512 watchdog clocks after time-out
// - external reset keeps three bits, clears others
// - cause flag: set, cleared, or kept per reset
// - power-on sets flag, clears reset enable
// - enable bit five gates the interrupt request
// - priority bit selects low or high priority
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module watchdog_control_status
#(
   parameter int TIMEOUT_TICKS = watchdog_control_pkg::DEF_TIMEOUT_TICKS
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // watchdog clock ticks, other reset sources and the global interrupt enable
   input  wire logic        subClockTick,
   input  wire logic        oscClockTick,
   input  wire logic        extReset,
   input  wire logic        powerFailReset,
   input  wire logic        globalIrqEnable,
   // interrupt and reset outputs
   output logic             wdtIrqReq,
   output logic             wdtIrqHighPri,
   output logic             wdtSystemReset,
   output logic             irq,
   // axi4-lite slave
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // =========================================================
   // counter widths and end values
   localparam int CW = $clog2(TIMEOUT_TICKS);
   // the delay counter runs 0..RESET_DELAY_TICKS-1, so the system reset
   // lands on the delay-th tick after the time-out tick, not one later
   localparam int DW = $clog2(watchdog_control_pkg::RESET_DELAY_TICKS + 1);
   localparam logic [CW-1:0] TO_LAST = CW'(TIMEOUT_TICKS - 1);
   localparam logic [DW-1:0] DLY_LAST = DW'(watchdog_control_pkg::RESET_DELAY_TICKS - 1);

   // the counter needs at least two states to tell restart from time-out
   if (TIMEOUT_TICKS < 2)
   begin : g_badParam
      $error("TIMEOUT_TICKS must be at least 2");
   end

   // =========================================================
   // state
   logic                  porFlag_reg;
   logic                  clkSel_reg;
   logic                  toFlag_reg;
   logic                  cause_reg;
   logic                  rstEn_reg;
   logic                  restart_reg;
   logic [watchdog_control_pkg::EIE_WIDTH-1:0] eie_reg;
   logic [watchdog_control_pkg::EIE_WIDTH-1:0] eip_reg;
   logic [watchdog_control_pkg::EV_COUNT-1:0]  irqSt_reg;
   logic [watchdog_control_pkg::EV_COUNT-1:0]  irqMsk_reg;
   logic [CW-1:0]         count_reg;
   logic [DW-1:0]         delay_reg;
   logic                  delayRun_reg;
   logic [11:0]           awAddr_reg;
   logic                  awHeld_reg;
   logic [31:0]           wData_reg;
   logic [3:0]            wStrb_reg;
   logic                  wHeld_reg;

   // =========================================================
   // bus write decode
   wire awTake   = s_axi_awvalid & s_axi_awready;
   wire wTake    = s_axi_wvalid & s_axi_wready;
   wire wrFire   = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
   // a response pending now or launched at this edge keeps both readies low
   wire bvalidNext = wrFire | (s_axi_bvalid & ~s_axi_bready);
   wire byte0    = wrFire & wStrb_reg[0];
   wire [7:0] wb = wData_reg[7:0];
   wire wrCtl    = byte0 & (awAddr_reg == watchdog_control_pkg::WDCTL_ADDR);
   wire wrEie    = byte0 & (awAddr_reg == watchdog_control_pkg::EIE_ADDR);
   wire wrEip    = byte0 & (awAddr_reg == watchdog_control_pkg::EIP_ADDR);
   wire wrSt     = byte0 & (awAddr_reg == watchdog_control_pkg::IRQST_ADDR);
   wire wrMsk    = byte0 & (awAddr_reg == watchdog_control_pkg::IRQMSK_ADDR);
   // unmapped addresses answer with a slave error and change nothing
   wire wrHit    = (awAddr_reg == watchdog_control_pkg::WDCTL_ADDR)
                 | (awAddr_reg == watchdog_control_pkg::EIE_ADDR)
                 | (awAddr_reg == watchdog_control_pkg::EIP_ADDR)
                 | (awAddr_reg == watchdog_control_pkg::IRQST_ADDR)
                 | (awAddr_reg == watchdog_control_pkg::IRQMSK_ADDR);

   // =========================================================
   // watchdog timing
   // selected tick gates the counter; ticks are one-cycle strobes
   wire tick      = clkSel_reg ? subClockTick : oscClockTick;
   wire timeout   = tick & ~restart_reg & (count_reg == TO_LAST);
   wire delayDone = delayRun_reg & tick & (delay_reg == DLY_LAST);
   // a watchdog reset only comes out of an armed delay
   wire wdReset   = delayDone & rstEn_reg;
   // any of the warm resets returns the soft fields to zero
   wire warmClr   = wdReset | extReset | powerFailReset;

   // restart and warm resets win over a tick in the same cycle
   wire [CW-1:0] countNext = (restart_reg | warmClr) ? '0
                           : tick ? ((count_reg == TO_LAST) ? '0 : count_reg + 1'b1)
                           : count_reg;
   // clearing the reset enable cancels a delay already under way
   wire delayStart = timeout & rstEn_reg & ~delayRun_reg;
   wire delayStop  = restart_reg | warmClr | ~rstEn_reg;
   wire delayRunNext = delayStop ? 1'b0 : (delayStart | delayRun_reg);
   wire [DW-1:0] delayNext = (delayStop | delayStart) ? '0
                           : (delayRun_reg & tick) ? delay_reg + 1'b1
                           : delay_reg;

   // =========================================================
   // control register next values
   // software may only clear the power-on flag
   wire porNext   = wrCtl ? (porFlag_reg & wb[watchdog_control_pkg::POR_BIT])
                          : porFlag_reg;
   wire clkSelNext = warmClr ? 1'b0
                   : wrCtl ? wb[watchdog_control_pkg::CLKSEL_BIT] : clkSel_reg;
   // a fresh time-out beats a software clear in the same cycle
   wire toNext    = warmClr ? 1'b0
                  : timeout ? 1'b1
                  : wrCtl ? (toFlag_reg & wb[watchdog_control_pkg::TOFLAG_BIT])
                  : toFlag_reg;
   wire causeNext = wdReset ? 1'b1
                  : powerFailReset ? 1'b0
                  : extReset ? cause_reg
                  : wrCtl ? (cause_reg & wb[watchdog_control_pkg::CAUSE_BIT])
                  : cause_reg;
   // only the power-on reset clears the reset enable; warm resets keep it
   wire rstEnNext = wrCtl ? wb[watchdog_control_pkg::RSTEN_BIT] : rstEn_reg;
   // restart lasts one cycle, then clears without software help
   wire restartNext = warmClr ? 1'b0
                    : wrCtl & wb[watchdog_control_pkg::RESTART_BIT];
   // interrupt enable and priority fall back to zero on every warm reset
   wire [watchdog_control_pkg::EIE_WIDTH-1:0] eieNext =
      warmClr ? watchdog_control_pkg::EIE_RESET
      : wrEie ? wb[watchdog_control_pkg::EIE_WIDTH-1:0] : eie_reg;
   wire [watchdog_control_pkg::EIE_WIDTH-1:0] eipNext =
      warmClr ? watchdog_control_pkg::EIP_RESET
      : wrEip ? wb[watchdog_control_pkg::EIE_WIDTH-1:0] : eip_reg;

   // =========================================================
   // sticky event bits, write one to clear, set wins
   // warm resets leave status and mask alone so software can still see why
   logic [watchdog_control_pkg::EV_COUNT-1:0] events;
   logic [watchdog_control_pkg::EV_COUNT-1:0] irqStNext;
   assign events[watchdog_control_pkg::EV_TIMEOUT] = timeout;
   assign events[watchdog_control_pkg::EV_WDRESET] = wdReset;
   for (genvar i = 0; i < watchdog_control_pkg::EV_COUNT; i++)
   begin : g_evt
      assign irqStNext[i] = events[i] | (irqSt_reg[i] & ~(wrSt & wb[i]));
   end
   wire [watchdog_control_pkg::EV_COUNT-1:0] irqMskNext =
      wrMsk ? wb[watchdog_control_pkg::EV_COUNT-1:0] : irqMsk_reg;

   // request goes out only with both enables set
   wire reqNext = toNext & eieNext[watchdog_control_pkg::WDT_EN_BIT]
                & globalIrqEnable;
   // priority is a plain copy of the register bit, with no gating
   wire priNext = eipNext[watchdog_control_pkg::WDT_EN_BIT];

   // =========================================================
   // read mux
   wire [7:0] ctlView = {1'b0, porFlag_reg, 1'b0, clkSel_reg, toFlag_reg,
                         cause_reg, rstEn_reg, restart_reg};
   // only byte 0 carries a register; the upper bytes read as zero
   logic [7:0] rdByte;
   logic       rdHit;
   always_comb
   begin
      rdByte = 8'h00;
      rdHit  = 1'b1;
      case (s_axi_araddr)
         watchdog_control_pkg::WDCTL_ADDR:  rdByte = ctlView;
         watchdog_control_pkg::EIE_ADDR:    rdByte = {2'b00, eie_reg};
         watchdog_control_pkg::EIP_ADDR:    rdByte = {2'b00, eip_reg};
         watchdog_control_pkg::IRQST_ADDR:  rdByte = {6'h00, irqSt_reg};
         watchdog_control_pkg::IRQMSK_ADDR: rdByte = {6'h00, irqMsk_reg};
         default:                           rdHit  = 1'b0;
      endcase
   end
   // read data is latched at the take, so a later change cannot tear it
   wire arTake = s_axi_arvalid & s_axi_arready;

   // =========================================================
   // power-on reset gives the documented control value
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         porFlag_reg <= 1'b1;
         clkSel_reg  <= 1'b0;
         toFlag_reg  <= 1'b0;
         cause_reg   <= 1'b0;
         rstEn_reg   <= 1'b0;
         restart_reg <= 1'b0;
         eie_reg     <= watchdog_control_pkg::EIE_RESET;
         eip_reg     <= watchdog_control_pkg::EIP_RESET;
      end
      else
      begin
         porFlag_reg <= porNext;
         clkSel_reg  <= clkSelNext;
         toFlag_reg  <= toNext;
         cause_reg   <= causeNext;
         rstEn_reg   <= rstEnNext;
         restart_reg <= restartNext;
         eie_reg     <= eieNext;
         eip_reg     <= eipNext;
      end
   end

   // counters and interrupt outputs
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         count_reg      <= '0;
         delay_reg      <= '0;
         delayRun_reg   <= 1'b0;
         irqSt_reg      <= '0;
         irqMsk_reg     <= '0;
         wdtIrqReq      <= 1'b0;
         wdtIrqHighPri  <= 1'b0;
         wdtSystemReset <= 1'b0;
         irq            <= 1'b0;
      end
      else
      begin
         count_reg      <= countNext;
         delay_reg      <= delayNext;
         delayRun_reg   <= delayRunNext;
         irqSt_reg      <= irqStNext;
         irqMsk_reg     <= irqMskNext;
         wdtIrqReq      <= reqNext;
         wdtIrqHighPri  <= priNext;
         wdtSystemReset <= wdReset;
         irq            <= |(irqStNext & irqMskNext);
      end
   end

   // =========================================================
   // write channels: address and data held until both are in
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         awHeld_reg    <= 1'b0;
         wHeld_reg     <= 1'b0;
         awAddr_reg    <= '0;
         wData_reg     <= '0;
         wStrb_reg     <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= watchdog_control_pkg::RESP_OKAY;
      end
      else
      begin
         if (awTake)
         begin
            awAddr_reg <= s_axi_awaddr;
         end
         if (wTake)
         begin
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         awHeld_reg    <= (awHeld_reg | awTake) & ~wrFire;
         wHeld_reg     <= (wHeld_reg | wTake) & ~wrFire;
         // ready drops as soon as a beat is taken or held, and stays low
         // until the response handshake, so a second write cannot queue up
         s_axi_awready <= ~((awHeld_reg | awTake) & ~wrFire) & ~bvalidNext;
         s_axi_wready  <= ~((wHeld_reg | wTake) & ~wrFire) & ~bvalidNext;
         if (wrFire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? watchdog_control_pkg::RESP_OKAY
                                  : watchdog_control_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel: one outstanding read, data captured at the take
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= watchdog_control_pkg::RESP_OKAY;
      end
      else
      begin
         // a new address is taken only once the previous data has gone
         s_axi_arready <= ~(s_axi_rvalid | arTake) | (s_axi_rvalid & s_axi_rready & ~arTake);
         if (arTake)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rdByte};
            s_axi_rresp  <= rdHit ? watchdog_control_pkg::RESP_OKAY
                                  : watchdog_control_pkg::RESP_SLVERR;
         end
         else if (s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : watchdog_control_status

// ### watchdog_control_status_chk.sv
// concurrent checks on the watchdog control and status ports, with their bind
`timescale 1ns/100ps
module watchdog_control_status_chk
#(
   parameter int TIMEOUT_TICKS = 16
)
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        subClockTick,
   input wire logic        oscClockTick,
   input wire logic        extReset,
   input wire logic        powerFailReset,
   input wire logic        globalIrqEnable,
   input wire logic        wdtIrqReq,
   input wire logic        wdtIrqHighPri,
   input wire logic        wdtSystemReset,
   input wire logic        irq,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // tick count since the last system reset; a bound, not a model
   logic [31:0] tickCnt_reg;
   wire         warmRst = extReset | powerFailReset | wdtSystemReset;
   wire         wdtEvt  = subClockTick | oscClockTick | wdtSystemReset;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         tickCnt_reg <= '0;
      end
      else if (wdtSystemReset)
      begin
         tickCnt_reg <= '0;
      end
      else if ((subClockTick || oscClockTick) && tickCnt_reg != '1)
      begin
         tickCnt_reg <= tickCnt_reg + 32'h1;
      end
   end
   // ==========================================================
   // watchdog outputs
   chk_irq_gated: assert property (wdtIrqReq |-> $past(globalIrqEnable))
      else $error("watchdog irq request while global enable was low");
   chk_pulse_single: assert property (wdtSystemReset |=> !wdtSystemReset)
      else $error("system reset pulse longer than one cycle");
   chk_reset_delay: assert property (wdtSystemReset |-> tickCnt_reg >= TIMEOUT_TICKS + watchdog_control_pkg::RESET_DELAY_TICKS)
      else $error("system reset before time-out plus delay ticks");
   // a watchdog reset moves the priority at the edge that raises its own pulse
   chk_prio_cause: assert property ($changed(wdtIrqHighPri) |-> s_axi_bvalid || $past(s_axi_bvalid)
      || $past(warmRst) || wdtSystemReset)
      else $error("priority output moved without a write or reset");
   chk_irq_cause: assert property ($rose(irq) |-> $past(wdtEvt) || $past(wdtEvt, 2)
      || $past(wdtEvt, 3) || s_axi_bvalid || $past(s_axi_bvalid))
      else $error("irq rose without an event or write");
   // ==========================================================
   // register bus handshakes
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before bready");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held until rready");
   chk_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while a response is pending");
   chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data is pending");
   cov_sys_reset: cover property (wdtSystemReset);
   cov_irq_req: cover property (wdtIrqReq);
   cov_irq_rise: cover property ($rose(irq));
endmodule : watchdog_control_status_chk

bind watchdog_control_status watchdog_control_status_chk #(.TIMEOUT_TICKS(TIMEOUT_TICKS)) i_watchdog_control_status_chk
(
   .sys_clk, .rst, .subClockTick, .oscClockTick, .extReset, .powerFailReset, .globalIrqEnable,
   .wdtIrqReq, .wdtIrqHighPri, .wdtSystemReset, .irq, .s_axi_awready, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

// ### watchdog_control_status_tb.sv
// self-checking bench for the watchdog control and status block
`timescale 1ns/100ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %h got %h", n, e, a); end end
module watchdog_control_status_tb;
   localparam int          TO  = 1024;
   localparam logic [11:0] CTL = watchdog_control_pkg::WDCTL_ADDR;
   localparam logic [11:0] EXTENDED_INTERRUPT_ENABLE = watchdog_control_pkg::EIE_ADDR;
   localparam logic [11:0] EXTENDED_INTERRUPT_PRIORITY = watchdog_control_pkg::EIP_ADDR;
   localparam logic [11:0] STS = watchdog_control_pkg::IRQST_ADDR;
   localparam logic [11:0] MSK = watchdog_control_pkg::IRQMSK_ADDR;
   localparam logic [1:0]  OK  = watchdog_control_pkg::RESP_OKAY;
   localparam logic [1:0]  ERR = watchdog_control_pkg::RESP_SLVERR;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        subClockTick = 1'b0;
   logic        oscClockTick = 1'b0;
   logic        extReset = 1'b0;
   logic        powerFailReset = 1'b0;
   logic        globalIrqEnable = 1'b0;
   logic        wdtIrqReq, wdtIrqHighPri, wdtSystemReset, irq;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int          compares = 0;
   int          miscompares = 0;
   int          pulses = 0;
   watchdog_control_status #(.TIMEOUT_TICKS(TO)) i_watchdog_control_status
   (
      .sys_clk, .rst, .subClockTick, .oscClockTick, .extReset, .powerFailReset, .globalIrqEnable,
      .wdtIrqReq, .wdtIrqHighPri, .wdtSystemReset, .irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   // ==========================================================
   // clock and system reset pulse counter
   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
      if (wdtSystemReset === 1'b1)
         pulses <= pulses + 1;
   // ==========================================================
   // run control and bus tasks; every wait is bounded
   task automatic complete_run();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic stop_if(input int n);
      if (n >= 50)
      begin
         miscompares++;
         complete_run();
      end
   endtask : stop_if
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      int         n;
      logic [1:0] resp;
      @(posedge sys_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         n++;
      end
      while (s_axi_bvalid !== 1'b1 && n < 50);
      // the response is taken at the edge where bvalid meets bready high
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      stop_if(n);
      `CHK("bresp", er, resp)
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
      int          n;
      logic [31:0] data;
      logic [1:0]  resp;
      @(posedge sys_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         n++;
      end
      while (s_axi_rvalid !== 1'b1 && n < 50);
      // data and response are taken at the edge where rvalid meets rready high
      data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      stop_if(n);
      `CHK("rdata", {24'h000000, e}, data)
      `CHK("rresp", er, resp)
   endtask : rd
   task automatic tick(input int n, input logic sub);
      repeat (n)
      begin
         @(posedge sys_clk);
         subClockTick <= sub;
         oscClockTick <= !sub;
         @(posedge sys_clk);
         subClockTick <= 1'b0;
         oscClockTick <= 1'b0;
      end
   endtask : tick
   // ==========================================================
   // main sequence
   initial
   begin
      cyc(3);
      rst <= 1'b0;
      rd(CTL, 8'h40, OK);
      rd(EXTENDED_INTERRUPT_ENABLE, 8'h00, OK);
      rd(12'h0f0, 8'h00, ERR);
      wr(12'h0f0, 8'hff, ERR);
      wr(EXTENDED_INTERRUPT_PRIORITY, 8'h20, OK);
      cyc(2);
      `CHK("highPri", 1'b1, wdtIrqHighPri)
      wr(EXTENDED_INTERRUPT_PRIORITY, 8'h00, OK);
      rd(EXTENDED_INTERRUPT_PRIORITY, 8'h00, OK);
      `CHK("highPri", 1'b0, wdtIrqHighPri)
      tick(20, 1'b1);
      tick(TO - 1, 1'b0);
      rd(CTL, 8'h40, OK);
      tick(1, 1'b0);
      rd(CTL, 8'h48, OK);
      wr(EXTENDED_INTERRUPT_ENABLE, 8'h20, OK);
      cyc(2);
      `CHK("irqReq", 1'b0, wdtIrqReq)
      globalIrqEnable <= 1'b1;
      cyc(3);
      `CHK("irqReq", 1'b1, wdtIrqReq)
      wr(EXTENDED_INTERRUPT_ENABLE, 8'h00, OK);
      cyc(2);
      `CHK("irqReq", 1'b0, wdtIrqReq)
      wr(CTL, 8'h40, OK);
      rd(CTL, 8'h40, OK);
      tick(600, 1'b0);
      wr(CTL, 8'h41, OK);
      rd(CTL, 8'h40, OK);
      tick(600, 1'b0);
      rd(CTL, 8'h40, OK);
      tick(TO - 600, 1'b0);
      rd(CTL, 8'h48, OK);
      wr(CTL, 8'h50, OK);
      tick(TO, 1'b0);
      rd(CTL, 8'h50, OK);
      tick(TO, 1'b1);
      rd(CTL, 8'h58, OK);
      extReset <= 1'b1;
      cyc(1);
      extReset <= 1'b0;
      rd(CTL, 8'h40, OK);
      tick(TO + 520, 1'b0);
      `CHK("sysResets", 0, pulses)
      rd(CTL, 8'h48, OK);
      wr(CTL, 8'h43, OK);
      tick(TO + 511, 1'b0);
      cyc(3);
      `CHK("sysResets", 0, pulses)
      tick(1, 1'b0);
      cyc(3);
      `CHK("sysResets", 1, pulses)
      rd(CTL, 8'h46, OK);
      rd(STS, 8'h03, OK);
      wr(MSK, 8'h02, OK);
      cyc(3);
      `CHK("irq", 1'b1, irq)
      wr(STS, 8'h02, OK);
      cyc(3);
      `CHK("irq", 1'b0, irq)
      wr(MSK, 8'h03, OK);
      cyc(3);
      `CHK("irq", 1'b1, irq)
      wr(STS, 8'h01, OK);
      rd(STS, 8'h00, OK);
      `CHK("irq", 1'b0, irq)
      extReset <= 1'b1;
      cyc(1);
      extReset <= 1'b0;
      rd(CTL, 8'h46, OK);
      powerFailReset <= 1'b1;
      cyc(1);
      powerFailReset <= 1'b0;
      rd(CTL, 8'h42, OK);
      wr(CTL, 8'h02, OK);
      rd(CTL, 8'h02, OK);
      rst <= 1'b1;
      cyc(3);
      rst <= 1'b0;
      rd(CTL, 8'h40, OK);
      complete_run();
   end
endmodule : watchdog_control_status_tb
